// file: dv/spd_dma_top_bench.sv
// Self-checking testbench of the serial ping-pong DMA block.
`timescale 1ns/10ps
module spd_dma_top_bench import spd_pkg::*;;
   localparam logic [31:0] RAM_A = 32'h2000_0000; // Buffer base in RAM.
   typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e; logic err;} spd_row_s;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rx_en = 0, room_en = 0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
   logic pready, perr, txf_room, txf_push, rxf_avail, rxf_pop, txm_ack, rxm_ack;
   logic [7:0] txf_data, rxf_data, txm_rdata;
   logic [3:0] flags;
   spd_mem_s txm_req, rxm_req;
   int failures = 0, check_count = 0;
   // Register rows: buffer bounds, an unmapped word, self-clearing resets.
   spd_row_s rows [10] = '{
      '{SPD_START_ADDR[0], RAM_A, RAM_A, 0}, '{SPD_START_ADDR[1], RAM_A + 16, RAM_A + 16, 0},
      '{SPD_START_ADDR[2], RAM_A, RAM_A, 0}, '{SPD_START_ADDR[3], RAM_A + 16, RAM_A + 16, 0},
      '{SPD_LAST_ADDR[0], RAM_A + 3, RAM_A + 3, 0}, '{SPD_LAST_ADDR[1], RAM_A + 17, RAM_A + 17, 0},
      '{SPD_LAST_ADDR[2], RAM_A + 3, RAM_A + 3, 0}, '{SPD_LAST_ADDR[3], RAM_A + 17, RAM_A + 17, 0},
      '{32'h4000_C83C, 32'hFFFF_FFFF, 32'h0000_0000, 1}, '{SPD_CTRL_ADDR, 32'h0000_0030, 32'h0000_0000, 0}};
   spd_dma_top spd_dma_top_i (.REF_CLK_I(clk), .SRST_I(rst), .CE_I(1'b1), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(perr), .TXF_ROOM_I(txf_room), .TXF_PUSH_O(txf_push),
      .TXF_DATA_O(txf_data), .RXF_AVAIL_I(rxf_avail), .RXF_DATA_I(rxf_data), .RXF_POP_O(rxf_pop),
      .TXM_REQ_O(txm_req), .TXM_ACK_I(txm_ack), .TXM_RDATA_I(txm_rdata), .RXM_REQ_O(rxm_req),
      .RXM_ACK_I(rxm_ack), .UNLOAD_FLAGS_O(flags));
   spd_far_model spd_far_model_i (.clk_i(clk), .rst_i(rst), .rx_en_i(rx_en), .room_en_i(room_en),
      .txm_req_i(txm_req), .rxm_req_i(rxm_req), .txf_push_i(txf_push), .txf_data_i(txf_data),
      .rxf_pop_i(rxf_pop), .txm_ack_o(txm_ack), .txm_rdata_o(txm_rdata), .rxm_ack_o(rxm_ack),
      .txf_room_o(txf_room), .rxf_avail_o(rxf_avail), .rxf_data_o(rxf_data));
   // Clock of 100 ns period.
   initial begin
      forever #50 clk = ~clk;
   end
   // Compares one value and counts it.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer; waits an edge first so strobes never change twice in a step.
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk("read data", x, r);
   endtask
   // Waits, bounded, for one unload flag.
   task automatic wait_flag(input int i);
      int n;
      n = 0;
      while (flags[i] !== 1'b1 && n < 500) begin
         @(posedge clk);
         n++;
      end
      chk("unload flag", 32'h1, {31'h0, flags[i]});
   endtask
   task automatic close_out();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard, far beyond the few hundred cycles the tests take.
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      close_out();
   end
   // Main sequence: reset, register rows, then the transfer and corner cases.
   initial begin
      logic [31:0] r;
      logic e;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(SPD_CTRL_ADDR, SPD_CTRL_RST); // all idle
      rd(SPD_FLAG_ADDR, 32'h0);
      rd(SPD_TXCNT_ADDR, SPD_CNT_RST);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0, r, e);
         chk("row data", rows[i].e, r);
         chk("row error", {31'h0, rows[i].err}, {31'h0, e});
      end
      wr(SPD_CTRL_ADDR, 32'h0000_0003);
      rd(SPD_CTRL_ADDR, 32'h0000_0003);
      rx_en <= 1'b1;
      wait_flag(1);
      rd(SPD_CTRL_ADDR, 32'h0);
      rd(SPD_FLAG_ADDR, 32'h3);
      rd(SPD_RXCNT_ADDR[0], 32'h4);
      rd(SPD_RXCNT_ADDR[1], 32'h2);
      for (int i = 0; i < 6; i++) begin
         chk("ram byte", i, spd_far_model_i.mem[i < 4 ? i : i + 12]);
      end
      rx_en <= 1'b0;
      room_en <= 1'b1;
      wr(SPD_CTRL_ADDR, 32'h0000_000C);
      wait_flag(3);
      rd(SPD_CTRL_ADDR, 32'h0);
      rd(SPD_TXCNT_ADDR, 32'h2);
      chk("pushed", 32'h6, spd_far_model_i.sent_n_q);
      for (int i = 0; i < 6; i++) begin
         chk("sent byte", i, spd_far_model_i.sent[i]);
      end
      wr(SPD_FLAG_ADDR, 32'hF);
      rd(SPD_FLAG_ADDR, 32'h0);
      wr(SPD_RXCNT_ADDR[0], 32'h3);
      rd(SPD_CTRL_ADDR, 32'h1);
      rd(SPD_RXCNT_ADDR[0], 32'h3);
      wr(SPD_CTRL_ADDR, 32'h0);
      rd(SPD_CTRL_ADDR, 32'h1);
      wr(SPD_LAST_ADDR[0], RAM_A + 2);
      rd(SPD_CTRL_ADDR, 32'h0);
      rd(SPD_FLAG_ADDR, 32'h1);
      wr(SPD_RXCNT_ADDR[1], 32'h1);
      wr(SPD_CTRL_ADDR, 32'h1);
      rd(SPD_CTRL_ADDR, 32'h3);
      wr(SPD_CTRL_ADDR, 32'h10);
      rd(SPD_CTRL_ADDR, 32'h0);
      rd(SPD_RXCNT_ADDR[1], 32'h0);
      wr(SPD_TXCNT_ADDR, 32'h5);
      wr(SPD_CTRL_ADDR, 32'h20);
      rd(SPD_TXCNT_ADDR, 32'h0);
      close_out();
   end
endmodule

// file: dv/spd_far_model.sv
// Far side model of the DMA block: serial FIFOs and a small byte RAM.
`timescale 1ns/10ps
module spd_far_model import spd_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rx_en_i,
   input wire logic room_en_i,
   input wire spd_mem_s txm_req_i,
   input wire spd_mem_s rxm_req_i,
   input wire logic txf_push_i,
   input wire logic [7:0] txf_data_i,
   input wire logic rxf_pop_i,
   output logic txm_ack_o,
   output logic [7:0] txm_rdata_o,
   output logic rxm_ack_o,
   output logic txf_room_o,
   output logic rxf_avail_o,
   output logic [7:0] rxf_data_o
);
   logic [7:0] mem [64]; // Byte RAM, only the low address bits decode.
   logic [7:0] sent [16]; // Bytes taken by the transmit FIFO.
   logic [4:0] sent_n_q; // Count of bytes taken.
   logic [7:0] seq_q; // Head byte of the receive FIFO.
   logic [1:0] wait_q; // Read latency counter, reads are slow.
   logic tog_q; // Makes the transmit FIFO stall every other cycle.
   // Reads answer late so the mover must hold its request.
   assign txm_ack_o = txm_req_i.vld && (wait_q == 2'd2);
   // Off the ack, the read lines show inverted data, never a stale byte.
   assign txm_rdata_o = txm_ack_o ? mem[txm_req_i.addr[5:0]] : ~mem[txm_req_i.addr[5:0]];
   assign rxm_ack_o = rxm_req_i.vld;
   assign txf_room_o = room_en_i & tog_q;
   assign rxf_avail_o = rx_en_i;
   assign rxf_data_o = rx_en_i ? seq_q : ~seq_q;
   // State of FIFOs and RAM moves on each edge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sent_n_q <= 5'h0;
         seq_q <= 8'h00;
         wait_q <= 2'h0;
         tog_q <= 1'b0;
      end else begin
         tog_q <= ~tog_q;
         wait_q <= (txm_req_i.vld && !txm_ack_o) ? wait_q + 2'h1 : 2'h0;
         if (rxf_pop_i) begin
            seq_q <= seq_q + 8'h01;
         end
         if (rxm_ack_o && rxm_req_i.we) begin
            mem[rxm_req_i.addr[5:0]] <= rxm_req_i.data;
         end
         if (txf_push_i && txf_room_o) begin
            sent[sent_n_q[3:0]] <= txf_data_i;
            sent_n_q <= sent_n_q + 5'h1;
         end
      end
   end
endmodule

// file: hdl/spd_chan.sv
// One DMA channel with two ping-pong buffers and its byte mover.
`timescale 1ns/10ps
module spd_chan import spd_pkg::*; #(
   parameter bit SEP_CNT = 1'b0,
   parameter bit IS_RX = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic chan_rst_i,
   input wire logic [1:0] load_i,
   input wire logic [1:0] cnt_wr_i,
   input wire logic [31:0] cnt_wdata_i,
   input wire logic [1:0][31:0] start_i,
   input wire logic [1:0][31:0] last_i,
   input wire logic fifo_vld_i,
   input wire logic [7:0] fifo_data_i,
   output logic fifo_stb_o,
   output logic [7:0] fifo_data_o,
   output spd_mem_s mem_o,
   input wire logic mem_ack_i,
   input wire logic [7:0] mem_rdata_i,
   output logic [1:0] loaded_o,
   output logic [1:0] active_o,
   output logic [1:0][31:0] cnt_o,
   output logic [1:0] unload_o
);

   spd_buf_e st_q [2]; // Buffer states.
   spd_buf_e st_d [2];
   logic [1:0][31:0] cnt_q; // Byte offsets; only index 0 is used when shared.
   logic [1:0][31:0] cnt_d;
   logic [1:0] unl_q; // One-cycle unload pulses.
   logic [1:0] unl_d;
   spd_xfer_e fsm_q; // Byte mover state.
   spd_xfer_e fsm_d;
   logic cur_q; // Buffer the byte in flight belongs to.
   logic cur_d;
   spd_mem_s mem_q; // RAM request, held until acknowledged.
   spd_mem_s mem_d;
   logic stb_q; // Rx pop pulse or tx push valid.
   logic stb_d;
   logic [7:0] dat_q; // Byte waiting for the tx FIFO.
   logic [7:0] dat_d;
   logic [31:0] eff; // Offset used in the unload check.
   logic act_any; // Some buffer is active after this cycle.
   logic act_idx; // Which buffer that is.

   // Map a buffer to its count register.
   function automatic int ci(input int b);
      return SEP_CNT ? b : 0;
   endfunction

   // Next state of buffers, counts and the byte mover.
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      unl_d = 2'b00;
      fsm_d = fsm_q;
      cur_d = cur_q;
      mem_d = mem_q;
      stb_d = stb_q;
      dat_d = dat_q;
      eff = SPD_CNT_RST;
      if (fsm_q == X_MEM && mem_ack_i && st_q[cur_q] == BUF_ACTIVE) begin
         cnt_d[ci(int'(cur_q))] = cnt_q[ci(int'(cur_q))] + SPD_CNT_STEP;
      end
      for (int b = 0; b < 2; b++) begin
         if (cnt_wr_i[b]) begin
            cnt_d[ci(b)] = cnt_wdata_i;
            if (IS_RX && st_q[b] == BUF_IDLE) begin
               st_d[b] = BUF_PENDING;
            end
         end else if (load_i[b] && st_q[b] == BUF_IDLE) begin
            st_d[b] = BUF_PENDING;
            if (SEP_CNT) begin
               cnt_d[b] = SPD_CNT_RST;
            end
         end
      end
      for (int b = 0; b < 2; b++) begin
         eff = (SEP_CNT || st_d[b] == BUF_ACTIVE) ? cnt_d[ci(b)] : SPD_CNT_RST;
         if (st_d[b] != BUF_IDLE && ({1'b0, start_i[b]} + {1'b0, eff}) > {1'b0, last_i[b]}) begin
            st_d[b] = BUF_IDLE;
            unl_d[b] = 1'b1;
         end
      end
      if (st_d[0] != BUF_ACTIVE && st_d[1] != BUF_ACTIVE) begin
         if (st_d[0] == BUF_PENDING) begin
            st_d[0] = BUF_ACTIVE;
            if (!SEP_CNT) begin
               cnt_d[0] = SPD_CNT_RST;
            end
         end else if (st_d[1] == BUF_PENDING) begin
            st_d[1] = BUF_ACTIVE;
            if (!SEP_CNT) begin
               cnt_d[0] = SPD_CNT_RST;
            end
         end
      end
      act_idx = (st_d[1] == BUF_ACTIVE);
      act_any = (st_d[0] == BUF_ACTIVE) || act_idx;
      unique case (fsm_q)
         X_IDLE: begin
            // A tx FIFO with room or an rx FIFO with data starts one byte.
            if (act_any && fifo_vld_i) begin
               cur_d = act_idx;
               mem_d.vld = 1'b1;
               mem_d.we = IS_RX;
               mem_d.addr = start_i[act_idx] + cnt_d[ci(int'(act_idx))];
               mem_d.data = fifo_data_i;
               stb_d = IS_RX;
               fsm_d = X_MEM;
            end
         end
         X_MEM: begin
            // The rx pop is one cycle wide.
            if (IS_RX) begin
               stb_d = 1'b0;
            end
            if (mem_ack_i) begin
               mem_d.vld = 1'b0;
               // The buffer's own last byte unloads it in this very cycle, so ownership is judged before
               // that unload; only a buffer already gone when the answer came loses its byte.
               if (!IS_RX && st_q[cur_q] == BUF_ACTIVE) begin
                  dat_d = mem_rdata_i;
                  stb_d = 1'b1;
                  fsm_d = X_FIFO;
               end else begin
                  fsm_d = X_IDLE;
               end
            end
         end
         X_FIFO: begin
            // Push is held until the FIFO shows room.
            if (fifo_vld_i) begin
               stb_d = 1'b0;
               fsm_d = X_IDLE;
            end
         end
      endcase
      if (chan_rst_i) begin
         st_d = '{BUF_IDLE, BUF_IDLE};
         cnt_d = '0;
         unl_d = 2'b00;
         fsm_d = X_IDLE;
         mem_d = '0;
         stb_d = 1'b0;
      end
   end

   // State registers; the clock enable freezes everything, but the synchronous reset still clears them while it is low.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '{BUF_IDLE, BUF_IDLE};
         cnt_q <= '0;
         unl_q <= 2'b00;
         fsm_q <= X_IDLE;
         cur_q <= 1'b0;
         mem_q <= '0;
         stb_q <= 1'b0;
         dat_q <= 8'h00;
      end else if (ce_i) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         unl_q <= unl_d;
         fsm_q <= fsm_d;
         cur_q <= cur_d;
         mem_q <= mem_d;
         stb_q <= stb_d;
         dat_q <= dat_d;
      end
   end

   always_comb begin
      for (int b = 0; b < 2; b++) begin
         loaded_o[b] = (st_q[b] != BUF_IDLE);
         active_o[b] = (st_q[b] == BUF_ACTIVE);
      end
   end
   assign cnt_o = cnt_q;
   assign unload_o = unl_q;
   assign mem_o = mem_q;
   assign fifo_stb_o = stb_q;
   assign fifo_data_o = dat_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_ONE_ACTIVE: assert property (!(active_o[0] && active_o[1])) else $error("two buffers active");
   AST_UNLOAD_IDLE: assert property (unl_q[0] |-> !loaded_o[0]) else $error("unloaded buffer still loaded");
   AST_OVER_UNLOAD: assert property ((ce_i && active_o[0] && !chan_rst_i &&
      ({1'b0, start_i[0]} + {1'b0, cnt_q[0]}) > {1'b0, last_i[0]}) |=> !active_o[0] && unl_q[0])
      else $error("buffer past its end not unloaded");
   AST_CNT_STEP: assert property ((ce_i && fsm_q == X_MEM && mem_ack_i && st_q[cur_q] == BUF_ACTIVE &&
      st_d[cur_q] == BUF_ACTIVE && !chan_rst_i && cnt_wr_i == 2'b00)
      |=> cnt_q[ci(int'(cur_q))] == $past(cnt_q[ci(int'(cur_q))]) + SPD_CNT_STEP)
      else $error("count did not step by one");
   AST_RST_CLEARS: assert property ((ce_i && chan_rst_i) |=> loaded_o == 2'b00 && cnt_q == '0 && !mem_q.vld)
      else $error("channel reset left state behind");
   AST_LOAD_PAIR: assert property ((ce_i && load_i == 2'b11 && !loaded_o[0] && !loaded_o[1] && !chan_rst_i)
      |=> (active_o[0] && !active_o[1]) || !loaded_o[0]) else $error("buffer B used before A");
   AST_MEM_HOLD: assert property ((mem_q.vld && !mem_ack_i && !chan_rst_i) |=> mem_q.vld && $stable(mem_q.addr))
      else $error("memory request dropped early");
   AST_CNT_LOAD: assert property ((ce_i && IS_RX && cnt_wr_i[0] && !chan_rst_i) |=> loaded_o[0] || unl_q[0])
      else $error("count write did not load buffer");

endmodule

// file: hdl/spd_dma_top.sv
// Serial ping-pong DMA block: APB registers and the transmit and receive channels.
`timescale 1ns/10ps
module spd_dma_top import spd_pkg::*; (
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [31:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic TXF_ROOM_I,
   output logic TXF_PUSH_O,
   output logic [7:0] TXF_DATA_O,
   input wire logic RXF_AVAIL_I,
   input wire logic [7:0] RXF_DATA_I,
   output logic RXF_POP_O,
   output spd_mem_s TXM_REQ_O,
   input wire logic TXM_ACK_I,
   input wire logic [7:0] TXM_RDATA_I,
   output spd_mem_s RXM_REQ_O,
   input wire logic RXM_ACK_I,
   output logic [3:0] UNLOAD_FLAGS_O
);

   // Buffer bounds, ordered rx A, rx B, tx A, tx B.
   logic [3:0][31:0] start_q;
   logic [3:0][31:0] start_d;
   logic [3:0][31:0] last_q;
   logic [3:0][31:0] last_d;
   // Sticky unload flags in the same order.
   logic [3:0] flag_q;
   logic [3:0] flag_d;
   logic [3:0] flag_clr;
   // Registered APB answer.
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;
   // Access phase not yet answered.
   logic acc;
   logic hit;
   // One-cycle commands into the channels.
   logic [1:0] rx_load;
   logic [1:0] tx_load;
   logic rx_rst;
   logic tx_rst;
   logic [1:0] rx_cnt_wr;
   logic [1:0] tx_cnt_wr;
   // Channel status.
   logic [1:0] rx_loaded;
   logic [1:0] tx_loaded;
   logic [1:0] rx_unl;
   logic [1:0] tx_unl;
   logic [1:0][31:0] rx_cnt;
   logic [1:0][31:0] tx_cnt;

   // The answer comes one cycle into the access phase, so with CE_I high every access has exactly one wait state.
   assign acc = PSEL_I && PENABLE_I && !pready_q;

   // Register decode, read mux and command pulses.
   always_comb begin
      start_d = start_q;
      last_d = last_q;
      prdata_d = SPD_CTRL_RST;
      pready_d = acc;
      pslverr_d = 1'b0;
      hit = 1'b0;
      flag_clr = 4'h0;
      rx_load = 2'b00;
      tx_load = 2'b00;
      rx_rst = 1'b0;
      tx_rst = 1'b0;
      rx_cnt_wr = 2'b00;
      tx_cnt_wr = 2'b00;
      if (acc) begin
         for (int i = 0; i < 4; i++) begin
            if (PADDR_I == SPD_START_ADDR[i]) begin
               hit = 1'b1;
               prdata_d = start_q[i];
               if (PWRITE_I) begin
                  start_d[i] = PWDATA_I;
               end
            end
            if (PADDR_I == SPD_LAST_ADDR[i]) begin
               hit = 1'b1;
               prdata_d = last_q[i];
               if (PWRITE_I) begin
                  last_d[i] = PWDATA_I;
               end
            end
         end
         if (PADDR_I == SPD_CTRL_ADDR) begin
            hit = 1'b1;
            prdata_d[SPD_RXLOAD_LSB +: 2] = rx_loaded;
            prdata_d[SPD_TXLOAD_LSB +: 2] = tx_loaded;
            if (PWRITE_I) begin
               rx_load = PWDATA_I[SPD_RXLOAD_LSB +: 2];
               tx_load = PWDATA_I[SPD_TXLOAD_LSB +: 2];
               rx_rst = PWDATA_I[SPD_RXRST_BIT];
               tx_rst = PWDATA_I[SPD_TXRST_BIT];
            end
         end
         if (PADDR_I == SPD_TXCNT_ADDR) begin
            hit = 1'b1;
            prdata_d = tx_cnt[0];
            tx_cnt_wr[0] = PWRITE_I;
         end
         for (int i = 0; i < 2; i++) begin
            if (PADDR_I == SPD_RXCNT_ADDR[i]) begin
               hit = 1'b1;
               prdata_d = rx_cnt[i];
               rx_cnt_wr[i] = PWRITE_I;
            end
         end
         if (PADDR_I == SPD_FLAG_ADDR) begin
            hit = 1'b1;
            prdata_d[3:0] = flag_q;
            if (PWRITE_I) begin
               flag_clr = PWDATA_I[3:0];
            end
         end
         // Unmapped addresses answer with an error and change nothing.
         pslverr_d = !hit;
      end
      flag_d = (flag_q & ~flag_clr) | {tx_unl, rx_unl};
   end

   // Register file and APB answer registers.
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         start_q <= {4{SPD_ADDR_RST}};
         last_q <= {4{SPD_ADDR_RST}};
         flag_q <= SPD_FLAG_RST;
         prdata_q <= SPD_CTRL_RST;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (CE_I) begin
         start_q <= start_d;
         last_q <= last_d;
         flag_q <= flag_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign PRDATA_O = prdata_q;
   assign PREADY_O = pready_q;
   assign PSLVERR_O = pslverr_q;
   assign UNLOAD_FLAGS_O = flag_q;

   // Receive channel: one count per buffer, pops the rx FIFO and writes RAM.
   spd_chan #(
      .SEP_CNT(1'b1),
      .IS_RX(1'b1)
   ) u_rx (
      .clk_i(REF_CLK_I),
      .rst_i(SRST_I),
      .ce_i(CE_I),
      .chan_rst_i(rx_rst),
      .load_i(rx_load),
      .cnt_wr_i(rx_cnt_wr),
      .cnt_wdata_i(PWDATA_I),
      .start_i(start_q[1:0]),
      .last_i(last_q[1:0]),
      .fifo_vld_i(RXF_AVAIL_I),
      .fifo_data_i(RXF_DATA_I),
      .fifo_stb_o(RXF_POP_O),
      .fifo_data_o(),
      .mem_o(RXM_REQ_O),
      .mem_ack_i(RXM_ACK_I),
      .mem_rdata_i(8'h00),
      .loaded_o(rx_loaded),
      .active_o(),
      .cnt_o(rx_cnt),
      .unload_o(rx_unl)
   );

   // Transmit channel: one shared count, reads RAM and pushes the tx FIFO.
   spd_chan #(
      .SEP_CNT(1'b0),
      .IS_RX(1'b0)
   ) u_tx (
      .clk_i(REF_CLK_I),
      .rst_i(SRST_I),
      .ce_i(CE_I),
      .chan_rst_i(tx_rst),
      .load_i(tx_load),
      .cnt_wr_i(tx_cnt_wr),
      .cnt_wdata_i(PWDATA_I),
      .start_i(start_q[3:2]),
      .last_i(last_q[3:2]),
      .fifo_vld_i(TXF_ROOM_I),
      .fifo_data_i(8'h00),
      .fifo_stb_o(TXF_PUSH_O),
      .fifo_data_o(TXF_DATA_O),
      .mem_o(TXM_REQ_O),
      .mem_ack_i(TXM_ACK_I),
      .mem_rdata_i(TXM_RDATA_I),
      .loaded_o(tx_loaded),
      .active_o(),
      .cnt_o(tx_cnt),
      .unload_o(tx_unl)
   );

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I || !CE_I);

   // An APB transfer: setup then access.
   sequence apb_setup_s;
      PSEL_I && !PENABLE_I;
   endsequence
   sequence apb_access_s;
      PSEL_I && PENABLE_I;
   endsequence

   AST_APB_ANSWER: assert property (apb_setup_s ##1 apb_access_s |=> PREADY_O)
      else $error("access not answered after one cycle");
   AST_CTRL_SELFCLR: assert property ((acc && !PWRITE_I && PADDR_I == SPD_CTRL_ADDR) |=> PRDATA_O[5:4] == 2'b00)
      else $error("reset bit read back as one");
   AST_LOAD_READ: assert property ((acc && !PWRITE_I && PADDR_I == SPD_CTRL_ADDR)
      |=> PRDATA_O[3:0] == $past({tx_loaded, rx_loaded})) else $error("load bits do not show status");
   AST_FLAG_SET: assert property (rx_unl[0] |=> UNLOAD_FLAGS_O[0]) else $error("unload flag not set");
   AST_LAST_WRITE: assert property ((acc && PWRITE_I && PADDR_I == SPD_LAST_ADDR[0])
      |=> last_q[0] == $past(PWDATA_I)) else $error("last address write lost");

endmodule

// file: include/spd_pkg.sv
// Shared constants, types and register map of the serial ping-pong DMA block.
package spd_pkg;

   // Control register address and reset value.
   localparam logic [31:0] SPD_CTRL_ADDR = 32'h4000_C830;
   localparam logic [31:0] SPD_CTRL_RST = 32'h0000_0000;
   // Control field positions.
   localparam int SPD_RXLOAD_LSB = 0;
   localparam int SPD_TXLOAD_LSB = 2;
   localparam int SPD_RXRST_BIT = 4;
   localparam int SPD_TXRST_BIT = 5;

   // Buffer index order used by every array of four: rx A, rx B, tx A, tx B.
   localparam logic [31:0] SPD_START_ADDR [4] = '{32'h4000_C800, 32'h4000_C804, 32'h4000_C808, 32'h4000_C80C};
   localparam logic [31:0] SPD_LAST_ADDR [4] = '{32'h4000_C810, 32'h4000_C814, 32'h4000_C818, 32'h4000_C81C};
   // Count registers: tx shared, rx A, rx B.
   localparam logic [31:0] SPD_TXCNT_ADDR = 32'h4000_C820;
   localparam logic [31:0] SPD_RXCNT_ADDR [2] = '{32'h4000_C824, 32'h4000_C828};
   // Sticky unload flags, write one to clear.
   localparam logic [31:0] SPD_FLAG_ADDR = 32'h4000_C834;

   // Reset values of the data registers and the count step.
   localparam logic [31:0] SPD_ADDR_RST = 32'h0000_0000;
   localparam logic [31:0] SPD_CNT_RST = 32'h0000_0000;
   localparam logic [31:0] SPD_CNT_STEP = 32'h0000_0001;
   localparam logic [3:0] SPD_FLAG_RST = 4'h0;

   // State of one memory buffer.
   typedef enum logic [1:0] {BUF_IDLE, BUF_PENDING, BUF_ACTIVE} spd_buf_e;
   // Byte mover sequence of a channel.
   typedef enum logic [1:0] {X_IDLE, X_MEM, X_FIFO} spd_xfer_e;

   // One byte request towards RAM.
   typedef struct packed {
      logic vld;
      logic we;
      logic [31:0] addr;
      logic [7:0] data;
   } spd_mem_s;

endpackage
